//--- core/umc_main_control.sv
// Added by the designer: strobed register access.
`timescale 1ns/100ps

// Contract
// - Writing one to bit 7 pulses reset of bus slave side and buffers; reset clears it.
// - Bit 6 reads one in high-speed mode, zero in full-speed mode.
// - Bit 5 enables packet buffer FIFO writes; writes ignored while zero.
// - Writing one to bit 4 starts controller soft reset; impossible in suspend.
// - Soft reset deasserts the power-saving output.
// - Soft reset terminates any chirp sequence in progress.
// - Soft reset empties the command FIFO.
// - Soft reset clears frame number, SOF mask timer and micro-frame number.
// - Soft reset leaves the data FIFO status unchanged.
// - Bit 3 enters suspend; hardware reset and bus reset clear it.
// - Bit 2 gates all interrupts globally.
// - Mask registers 0x11 to 0x17 suppress interrupt sources individually.
// - Bit 1 flushes burst buffer to FIFO; hardware clears it when done.
// - Bit 0 lets a wakeup signal end suspend.
// - Configured flag zero makes non-control transfers time out; bus reset clears it.
// - Bits 6..0 hold the assigned address; both resets clear it.
module umc_main_control (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_enable,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Link status
  input  wire logic        usb_bus_reset,
  input  wire logic        high_speed_mode,
  input  wire logic        wakeup_signal,
  input  wire logic        chirp_active,
  // Packet buffer write request
  input  wire logic        fifo_write_req,
  output logic             fifo_write_strobe,
  // Burst buffer flush handshake
  input  wire logic        flush_done,
  output logic             flush_request,
  // Token decode
  input  wire logic        token_valid,
  input  wire logic [6:0]  token_address,
  input  wire logic        token_is_control,
  output logic             token_respond,
  // Interrupt sources (one byte per mask register)
  input  wire logic [55:0] irq_sources,
  output logic             irq_out,
  // Reset and power outputs
  output logic             bus_side_reset,
  output logic             controller_soft_reset,
  output logic             chirp_abort,
  output logic             command_fifo_clear,
  output logic             frame_counters_clear,
  output logic             suspend_active,
  output logic             power_saving_output,
  output logic             wakeup_resume
);
  import umc_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic       fifo_write_en_q;
  logic       soft_reset_q;
  logic       suspend_request_q;
  logic       global_irq_enable_q;
  logic       flush_q;
  logic       remote_wakeup_capable_q;
  logic       configured_flag_q;
  logic [6:0] assigned_address_q;
  logic [2:0] flush_cnt_q;
  logic [7:0] irq_mask_q [UMC_IRQ_GROUPS];

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire        wr_main    = reg_write && (reg_addr == UMC_ADDR_MAIN_CONTROL);
  wire        wr_addr    = reg_write && (reg_addr == UMC_ADDR_DEVICE_ADDRESS);
  wire        mask_hit   = (reg_addr >= UMC_ADDR_IRQ_MASK_LO) &&
                           (reg_addr <= UMC_ADDR_IRQ_MASK_HI);
  wire [2:0]  mask_idx   = 3'(reg_addr - UMC_ADDR_IRQ_MASK_LO);
  // A soft reset request is refused while the suspend bit is set, so it is never taken then
  wire        soft_set   = wr_main && reg_wdata[UMC_BIT_SOFT_RESET]
                           && !suspend_request_q;
  wire        bus_set    = wr_main && reg_wdata[UMC_BIT_BUS_SIDE_RESET];
  wire        flush_end  = flush_q && (flush_done || flush_cnt_q == UMC_FLUSH_LAST);
  wire        wake_hit   = suspend_request_q && remote_wakeup_capable_q
                           && wakeup_signal;

  wire [7:0]  main_view  = {1'b0, high_speed_mode, fifo_write_en_q, soft_reset_q,
                            suspend_request_q, global_irq_enable_q, flush_q,
                            remote_wakeup_capable_q};
  wire [7:0]  addr_view  = {configured_flag_q, assigned_address_q};
  wire [7:0]  read_mux   = (reg_addr == UMC_ADDR_MAIN_CONTROL)   ? main_view :
                           (reg_addr == UMC_ADDR_DEVICE_ADDRESS) ? addr_view :
                           mask_hit ? irq_mask_q[mask_idx] : 8'h00;

  // Each mask byte gates one byte of sources; any unmasked one raises the line while global enable bit 2 is set
  logic [UMC_IRQ_GROUPS-1:0] group_hit;
  for (genvar g = 0; g < UMC_IRQ_GROUPS; g++) begin : g_irq
    assign group_hit[g] = |(irq_sources[8*g +: 8] & ~irq_mask_q[g]);
  end
  wire        irq_d      = global_irq_enable_q && (|group_hit);

  // Non-control traffic is ignored until configured, letting the host time out
  wire        token_ok   = token_valid && (token_address == assigned_address_q)
                           && (token_is_control || configured_flag_q);

  // ---------------------------------------------------------------
  // Main control register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      fifo_write_en_q         <= 1'b0;
      soft_reset_q            <= 1'b0;
      global_irq_enable_q     <= 1'b0;
      remote_wakeup_capable_q <= 1'b0;
    end else if (clock_enable) begin
      // Soft reset is a one-cycle pulse; it self-clears
      soft_reset_q <= soft_set;
      if (wr_main) begin
        fifo_write_en_q         <= reg_wdata[UMC_BIT_FIFO_WRITE_EN];
        global_irq_enable_q     <= reg_wdata[UMC_BIT_GLOBAL_IRQ];
        remote_wakeup_capable_q <= reg_wdata[UMC_BIT_WAKEUP_CAPABLE];
      end
    end
  end

  // Suspend: bus reset and accepted wakeup leave it
  always_ff @(posedge clock) begin
    if (reset) begin
      suspend_request_q <= 1'b0;
    end else if (clock_enable) begin
      if (usb_bus_reset || wake_hit) begin
        suspend_request_q <= 1'b0;
      end else if (wr_main) begin
        suspend_request_q <= reg_wdata[UMC_BIT_SUSPEND];
      end
    end
  end

  // Flush: hardware clears on completion; a new request wins over the clear
  always_ff @(posedge clock) begin
    if (reset) begin
      flush_q     <= 1'b0;
      flush_cnt_q <= 3'h0;
    end else if (clock_enable) begin
      if (wr_main && reg_wdata[UMC_BIT_FLUSH]) begin
        flush_q     <= 1'b1;
        flush_cnt_q <= 3'h0;
      end else if (flush_end) begin
        flush_q <= 1'b0;
      end else if (flush_q) begin
        flush_cnt_q <= flush_cnt_q + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Device address register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      configured_flag_q  <= 1'b0;
      assigned_address_q <= UMC_RST_ADDRESS;
    end else if (clock_enable) begin
      if (usb_bus_reset) begin
        configured_flag_q  <= 1'b0;
        assigned_address_q <= UMC_RST_ADDRESS;
      end else if (wr_addr) begin
        configured_flag_q  <= reg_wdata[UMC_BIT_CONFIGURED];
        assigned_address_q <= reg_wdata[6:0];
      end
    end
  end

  // Interrupt mask bytes
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < UMC_IRQ_GROUPS; i++) irq_mask_q[i] <= UMC_RST_IRQ_MASK;
    end else if (clock_enable && reg_write && mask_hit) begin
      irq_mask_q[mask_idx] <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata             <= 8'h00;
      fifo_write_strobe     <= 1'b0;
      token_respond         <= 1'b0;
      irq_out               <= 1'b0;
      bus_side_reset        <= 1'b0;
      controller_soft_reset <= 1'b0;
      chirp_abort           <= 1'b0;
      command_fifo_clear    <= 1'b0;
      frame_counters_clear  <= 1'b0;
      power_saving_output   <= 1'b0;
      wakeup_resume         <= 1'b0;
    end else if (clock_enable) begin
      reg_rdata             <= reg_read ? read_mux : 8'h00;
      fifo_write_strobe     <= fifo_write_req && fifo_write_en_q;
      token_respond         <= token_ok;
      irq_out               <= irq_d;
      bus_side_reset        <= bus_set;
      // Soft reset stays off the buffer side, so the data FIFO status survives it
      controller_soft_reset <= soft_set;
      chirp_abort           <= soft_set && chirp_active;
      command_fifo_clear    <= soft_set;
      frame_counters_clear  <= soft_set;
      power_saving_output   <= soft_set ? 1'b0 : suspend_request_q;
      wakeup_resume         <= wake_hit;
    end
  end

  assign flush_request  = flush_q;
  assign suspend_active = suspend_request_q;

  // ---------------------------------------------------------------
  // Assertions: register port and control bits
  // ---------------------------------------------------------------
  a_soft_no_suspend: assert property (@(posedge clock) disable iff (reset)
    clock_enable && wr_main && reg_wdata[UMC_BIT_SOFT_RESET] && suspend_request_q
      |=> !controller_soft_reset)
    else $error("Soft reset taken in suspend");

  a_soft_pulse: assert property (@(posedge clock) disable iff (reset)
    clock_enable && soft_reset_q && !soft_set |=> !soft_reset_q)
    else $error("Soft reset bit did not self-clear");

  a_fifo_gated: assert property (@(posedge clock) disable iff (reset)
    $past(clock_enable) && fifo_write_strobe
      |-> $past(fifo_write_en_q) && $past(fifo_write_req))
    else $error("FIFO write without enable");

  a_fifo_refused: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !(fifo_write_req && fifo_write_en_q) |=> !fifo_write_strobe)
    else $error("FIFO write passed while refused");

  a_speed_view: assert property (@(posedge clock) disable iff (reset)
    clock_enable && reg_read && reg_addr == UMC_ADDR_MAIN_CONTROL
      |=> reg_rdata[UMC_BIT_SPEED] == $past(high_speed_mode))
    else $error("Speed bit does not follow the link");

  a_irq_global: assert property (@(posedge clock) disable iff (reset)
    $past(clock_enable) && irq_out |-> $past(global_irq_enable_q))
    else $error("Interrupt while globally disabled");

  a_irq_on: assert property (@(posedge clock) disable iff (reset)
    clock_enable && global_irq_enable_q && (|group_hit) |=> irq_out)
    else $error("Unmasked interrupt not raised");

  a_irq_mask: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !(|group_hit) |=> !irq_out)
    else $error("Masked interrupt raised");

  a_flush_bounded: assert property (@(posedge clock) disable iff (reset)
    clock_enable && flush_q && flush_cnt_q == UMC_FLUSH_LAST
      && !(wr_main && reg_wdata[UMC_BIT_FLUSH]) |=> !flush_q)
    else $error("Flush did not complete");

  a_flush_done: assert property (@(posedge clock) disable iff (reset)
    clock_enable && flush_q && flush_done && !(wr_main && reg_wdata[UMC_BIT_FLUSH])
      |=> !flush_q)
    else $error("Flush bit kept after completion");

  // ---------------------------------------------------------------
  // Assertions: soft reset, bus reset and power
  // ---------------------------------------------------------------
  a_soft_clears_pwr: assert property (@(posedge clock) disable iff (reset)
    clock_enable && soft_set |=> !power_saving_output && command_fifo_clear)
    else $error("Power saving not deasserted by soft reset");

  a_chirp_abort: assert property (@(posedge clock) disable iff (reset)
    clock_enable && soft_set && chirp_active |=> chirp_abort)
    else $error("Chirp not terminated");

  a_chirp_quiet: assert property (@(posedge clock) disable iff (reset)
    $past(clock_enable) && chirp_abort |-> $past(soft_set))
    else $error("Chirp abort without soft reset");

  a_cmd_fifo_clear: assert property (@(posedge clock) disable iff (reset)
    $past(clock_enable) && command_fifo_clear |-> $past(soft_set))
    else $error("Command FIFO cleared without soft reset");

  a_frame_clear: assert property (@(posedge clock) disable iff (reset)
    clock_enable && soft_set |=> frame_counters_clear)
    else $error("Frame counters not cleared");

  a_no_data_clear: assert property (@(posedge clock) disable iff (reset)
    clock_enable && soft_set && !bus_set |=> !bus_side_reset)
    else $error("Soft reset reached the buffer side");

  a_bus_side_pulse: assert property (@(posedge clock) disable iff (reset)
    clock_enable && bus_set |=> bus_side_reset)
    else $error("Bus side reset not pulsed");

  a_bus_side_once: assert property (@(posedge clock) disable iff (reset)
    $past(clock_enable) && bus_side_reset |-> $past(bus_set))
    else $error("Bus side reset without request");

  a_bus_rst_susp: assert property (@(posedge clock) disable iff (reset)
    clock_enable && usb_bus_reset |=> !suspend_request_q && assigned_address_q == 7'h00)
    else $error("Bus reset did not clear state");

  a_power_follows: assert property (@(posedge clock) disable iff (reset)
    clock_enable && suspend_request_q && !soft_set |=> power_saving_output)
    else $error("Power saving not raised in suspend");

  a_state_frozen: assert property (@(posedge clock) disable iff (reset)
    !clock_enable |=> $stable(suspend_request_q) && $stable(flush_q)
      && $stable(configured_flag_q))
    else $error("State changed while clock enable low");

  // ---------------------------------------------------------------
  // Assertions: wakeup, address and tokens
  // ---------------------------------------------------------------
  a_wakeup_exit: assert property (@(posedge clock) disable iff (reset)
    clock_enable && wake_hit |=> !suspend_request_q && wakeup_resume)
    else $error("Wakeup did not end suspend");

  a_wake_needs_cap: assert property (@(posedge clock) disable iff (reset)
    $past(clock_enable) && wakeup_resume
      |-> $past(remote_wakeup_capable_q) && $past(suspend_request_q))
    else $error("Wakeup accepted without capability");

  a_addr_write: assert property (@(posedge clock) disable iff (reset)
    clock_enable && wr_addr && !usb_bus_reset
      |=> assigned_address_q == $past(reg_wdata[6:0]))
    else $error("Address write not stored");

  a_addr_hold: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !usb_bus_reset && !wr_addr |=> $stable(assigned_address_q))
    else $error("Address changed without write");

  a_config_cleared: assert property (@(posedge clock) disable iff (reset)
    clock_enable && usb_bus_reset |=> !configured_flag_q)
    else $error("Bus reset left configured flag set");

  a_token_match: assert property (@(posedge clock) disable iff (reset)
    $past(clock_enable) && token_respond
      |-> $past(token_address) == $past(assigned_address_q))
    else $error("Response to foreign address");

  a_unconf_silent: assert property (@(posedge clock) disable iff (reset)
    $past(clock_enable) && token_respond && !$past(token_is_control)
      |-> $past(configured_flag_q))
    else $error("Non-control response before configuration");

  a_foreign_silent: assert property (@(posedge clock) disable iff (reset)
    clock_enable && token_valid && token_address != assigned_address_q |=> !token_respond)
    else $error("Token for another address answered");

endmodule : umc_main_control

//--- core/umc_pkg.sv
package umc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] UMC_ADDR_MAIN_CONTROL   = 8'h00;
  localparam logic [7:0] UMC_ADDR_DEVICE_ADDRESS = 8'h01;
  localparam logic [7:0] UMC_ADDR_IRQ_MASK_LO    = 8'h11;
  localparam logic [7:0] UMC_ADDR_IRQ_MASK_HI    = 8'h17;
  localparam int         UMC_IRQ_GROUPS          = 7;

  // ---------------------------------------------------------------
  // Main control bit positions
  // ---------------------------------------------------------------
  localparam int UMC_BIT_BUS_SIDE_RESET  = 7;
  localparam int UMC_BIT_SPEED           = 6;
  localparam int UMC_BIT_FIFO_WRITE_EN   = 5;
  localparam int UMC_BIT_SOFT_RESET      = 4;
  localparam int UMC_BIT_SUSPEND         = 3;
  localparam int UMC_BIT_GLOBAL_IRQ      = 2;
  localparam int UMC_BIT_FLUSH           = 1;
  localparam int UMC_BIT_WAKEUP_CAPABLE  = 0;

  // Device address fields
  localparam int UMC_BIT_CONFIGURED      = 7;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] UMC_RST_MAIN_CONTROL   = 8'h00;
  localparam logic [6:0] UMC_RST_ADDRESS        = 7'h00;
  localparam logic [7:0] UMC_RST_IRQ_MASK       = 8'h00;
  localparam int         UMC_FLUSH_CYCLES       = 4;
  localparam logic [2:0] UMC_FLUSH_LAST         = 3'(UMC_FLUSH_CYCLES - 1);

endpackage : umc_pkg

//--- verif/umc_usb_host.sv
`timescale 1ns/100ps

// ---------------------------------------------------------------
// Upstream host model: link status and token stream
// ---------------------------------------------------------------
module umc_usb_host (
  // Clock
  input  wire logic  clock,
  // Link status
  output logic       usb_bus_reset,
  output logic       high_speed_mode,
  output logic       wakeup_signal,
  output logic       chirp_active,
  // Token stream
  output logic       token_valid,
  output logic [6:0] token_address,
  output logic       token_is_control
);
  initial begin
    usb_bus_reset    = 1'b0;
    high_speed_mode  = 1'b0;
    wakeup_signal    = 1'b0;
    chirp_active     = 1'b0;
    token_valid      = 1'b0;
    token_address    = 7'h7f;
    token_is_control = 1'b0;
  end

  task automatic set_status(input logic hs, input logic chirp, input logic wake);
    @(posedge clock);
    high_speed_mode <= hs;
    chirp_active    <= chirp;
    wakeup_signal   <= wake;
  endtask : set_status

  // Outside a token the fields show inverted junk, never the last value
  task automatic send_token(input logic [6:0] addr, input logic ctrl);
    @(posedge clock);
    token_valid      <= 1'b1;
    token_address    <= addr;
    token_is_control <= ctrl;
    @(posedge clock);
    token_valid      <= 1'b0;
    token_address    <= ~addr;
    token_is_control <= ~ctrl;
  endtask : send_token

  task automatic bus_reset();
    @(posedge clock);
    usb_bus_reset <= 1'b1;
    @(posedge clock);
    usb_bus_reset <= 1'b0;
  endtask : bus_reset
endmodule : umc_usb_host

//--- verif/usb_device_main_control_test.sv
`timescale 1ns/100ps

module usb_device_main_control_test;
  import umc_pkg::*;
  logic        clock, reset, clock_enable, reg_write, reg_read, fifo_write_req, flush_done;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [55:0] irq_sources;
  logic        usb_bus_reset, high_speed_mode, wakeup_signal, chirp_active;
  logic        token_valid, token_is_control, fifo_write_strobe, flush_request, token_respond;
  logic [6:0]  token_address;
  logic        irq_out, bus_side_reset, controller_soft_reset, chirp_abort, command_fifo_clear;
  logic        frame_counters_clear, suspend_active, power_saving_output, wakeup_resume;
  int          err_count, checked;

  umc_usb_host host (.clock, .usb_bus_reset, .high_speed_mode, .wakeup_signal, .chirp_active,
    .token_valid, .token_address, .token_is_control);
  umc_main_control dut (.clock, .reset, .clock_enable, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .usb_bus_reset, .high_speed_mode, .wakeup_signal, .chirp_active,
    .fifo_write_req, .fifo_write_strobe, .flush_done, .flush_request, .token_valid,
    .token_address, .token_is_control, .token_respond, .irq_sources, .irq_out, .bus_side_reset,
    .controller_soft_reset, .chirp_abort, .command_fifo_clear, .frame_counters_clear,
    .suspend_active, .power_saving_output, .wakeup_resume);

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // ---------------------------------------------------------------
  // Register port tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step();
    @(posedge clock);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd
  task automatic pulse_in(input logic to_flush);
    @(posedge clock);
    if (to_flush) begin
      flush_done <= 1'b1;
    end else begin
      fifo_write_req <= 1'b1;
    end
    @(posedge clock);
    fifo_write_req <= 1'b0;
    flush_done     <= 1'b0;
    #1;
  endtask : pulse_in
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // Sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    print_verdict();
  end

  initial begin
    {reset, clock_enable} = 2'b11;
    {reg_write, reg_read, fifo_write_req, flush_done} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    irq_sources = 56'h00_0000_0000_0001;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    rd(8'h00, 8'h00, "main_control");
    rd(8'h01, 8'h00, "device_address");
    rd(8'h05, 8'h00, "unmapped");
    host.set_status(1'b1, 1'b1, 1'b0);
    rd(8'h00, 8'h40, "speed_indicator");
    wr(8'h00, 8'h10);
    chk("soft_reset", 8'h01, 8'(controller_soft_reset));
    chk("chirp_abort", 8'h01, 8'(chirp_abort));
    chk("cmd_fifo_clear", 8'h01, 8'(command_fifo_clear));
    chk("frame_clear", 8'h01, 8'(frame_counters_clear));
    chk("power_save_soft", 8'h00, 8'(power_saving_output));
    chk("data_fifo_kept", 8'h00, 8'(bus_side_reset));
    step();
    chk("soft_reset_end", 8'h00, 8'(controller_soft_reset));
    wr(8'h00, 8'h80);
    chk("bus_side_reset", 8'h01, 8'(bus_side_reset));
    rd(8'h00, 8'h40, "bus_side_bit");
    pulse_in(1'b0);
    chk("fifo_blocked", 8'h00, 8'(fifo_write_strobe));
    wr(8'h00, 8'h22);
    pulse_in(1'b0);
    chk("fifo_write", 8'h01, 8'(fifo_write_strobe));
    chk("flush_req", 8'h01, 8'(flush_request));
    pulse_in(1'b1);
    chk("flush_clear", 8'h00, 8'(flush_request));
    rd(8'h00, 8'h60, "flush_bit");
    // Without a done pulse the flush must end on its own cycle limit
    wr(8'h00, 8'h22);
    repeat (UMC_FLUSH_CYCLES - 1) step();
    chk("flush_hold", 8'h01, 8'(flush_request));
    step();
    chk("flush_timeout", 8'h00, 8'(flush_request));
    repeat (2) step();
    chk("irq_gated", 8'h00, 8'(irq_out));
    wr(8'h00, 8'h24);
    repeat (2) step();
    chk("irq_on", 8'h01, 8'(irq_out));
    wr(UMC_ADDR_IRQ_MASK_LO, 8'h01);
    repeat (2) step();
    chk("irq_masked", 8'h00, 8'(irq_out));
    rd(UMC_ADDR_IRQ_MASK_LO, 8'h01, "irq_mask");
    // Writes while the clock enable is low must leave every register alone
    @(posedge clock);
    clock_enable <= 1'b0;
    wr(8'h01, 8'h7f);
    wr(8'h00, 8'h08);
    @(posedge clock);
    clock_enable <= 1'b1;
    rd(8'h01, 8'h00, "frozen_address");
    chk("frozen_suspend", 8'h00, 8'(suspend_active));
    // Port idle: park the controller in suspend
    wr(8'h00, 8'h08);
    step();
    chk("suspend", 8'h01, 8'(suspend_active));
    chk("power_save", 8'h01, 8'(power_saving_output));
    wr(8'h00, 8'h18);
    chk("soft_reset_susp", 8'h00, 8'(controller_soft_reset));
    wr(8'h00, 8'h09);
    host.set_status(1'b1, 1'b0, 1'b1);
    step();
    chk("wakeup", 8'h01, 8'(wakeup_resume));
    chk("woken", 8'h00, 8'(suspend_active));
    host.set_status(1'b1, 1'b0, 1'b0);
    wr(8'h00, 8'h08);
    host.bus_reset();
    #1;
    chk("bus_reset_susp", 8'h00, 8'(suspend_active));
    wr(8'h01, 8'h05);
    rd(8'h01, 8'h05, "assigned_address");
    host.send_token(7'h05, 1'b0);
    #1;
    chk("unconfigured", 8'h00, 8'(token_respond));
    host.send_token(7'h05, 1'b1);
    #1;
    chk("control_token", 8'h01, 8'(token_respond));
    wr(8'h01, 8'h85);
    host.send_token(7'h05, 1'b0);
    #1;
    chk("configured", 8'h01, 8'(token_respond));
    host.send_token(7'h06, 1'b0);
    #1;
    chk("other_address", 8'h00, 8'(token_respond));
    host.bus_reset();
    rd(8'h01, 8'h00, "addr_bus_reset");
    print_verdict();
  end
endmodule : usb_device_main_control_test
